//--- core/bcs_pkg.sv
// Package: constants and carriers for the battery query responder
package bcs_pkg;

  // APB byte offsets
  localparam logic [11:0] BCS_CTRL_OFS = 12'h000;
  localparam logic [11:0] BCS_SRC_OFS = 12'h004;
  localparam logic [11:0] BCS_STAT_OFS = 12'h008;
  localparam logic [11:0] BCS_ID_OFS = 12'h040;
  localparam logic [11:0] BCS_CAP_OFS = 12'h060;

  // Reset values
  localparam logic [31:0] BCS_CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] BCS_SRC_RST = 16'h0000;
  localparam logic [31:0] BCS_WORD_RST = 32'h0000_0000;

  // Battery counts and index ranges
  localparam int BCS_NBAT = 8;
  localparam logic [7:0] BCS_LAST_REF = 8'h07;
  localparam int BCS_HS_BIT = 2;

  // Extended header data sizes
  localparam logic [7:0] BCS_REQ_SIZE = 8'h01;
  localparam logic [7:0] BCS_CAP_SIZE = 8'h09;

  // Capacity codes
  localparam logic [15:0] BCS_CAP_ABSENT = 16'h0000;
  localparam logic [15:0] BCS_CAP_UNKNOWN = 16'hffff;

  // Field positions
  localparam int BCS_TYPE_INVALID = 0;
  localparam int BCS_TYPE_HOTSWAP = 1;
  localparam int BCS_PSI_BATTERY = 3;
  localparam int BCS_STAT_VALID = 8;
  localparam int BCS_STAT_SZERR = 9;

  // Request from the protocol engine
  typedef struct packed {
    logic valid;
    logic is_status;
    logic [7:0] size;
    logic [7:0] ref_idx;
  } bcs_req_t;

  // Capability reply toward the message builder
  typedef struct packed {
    logic valid;
    logic [7:0] size;
    logic [71:0] block;
  } bcs_cap_t;

  // Status request toward the status object builder
  typedef struct packed {
    logic valid;
    logic [7:0] ref_idx;
  } bcs_stat_t;

endpackage

//--- core/bcs_responder.sv
// Battery capability and status query responder with APB registers
`timescale 1ns/100ps

// Register bus side: APB with no wait states. A read word is latched
// in the setup cycle and stands through the access cycle, so software
// sees the value from the setup edge, never one changed during access.
// Query side: the protocol engine hands over one decoded request a
// cycle, as a single-cycle strobe with size and reference byte.
// Capability requests are answered one cycle later with the whole
// nine-byte block in parallel; the message builder serialises it.
// Status requests are only passed on, since the status object is
// assembled elsewhere from live battery data.
// Battery data lives in software-written words; keeping it in
// registers trades area for a reply that never waits on firmware.
// Limitation: presence bits only matter for the hot swap half, so
// firmware cannot mark a fixed battery absent through them.
// A size error is sticky until software clears it.
// Both sides share the one clock, so no input needs a
// synchroniser in front of it.
module bcs_responder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bcs_pkg::bcs_req_t req,
  output bcs_pkg::bcs_cap_t cap_rsp,
  output bcs_pkg::bcs_stat_t stat_req,
  output logic [7:0] bat_supply,
  output logic bat_supply_valid
);
  import bcs_pkg::*;

  // Whole module state in one word
  typedef struct packed {
    // Battery masks written by software
    logic [31:0] ctrl;
    // Present source input and battery input bitmap
    logic [15:0] src;
    // Sticky flag for a request of the wrong size
    logic size_err;
    // Reference of the latest query, and replies sent so far
    logic [7:0] last_ref;
    logic [7:0] cap_cnt;
    // Identifier and capacity words, one pair per battery
    logic [BCS_NBAT-1:0][31:0] idw;
    logic [BCS_NBAT-1:0][31:0] capw;
    // Bus answer, latched in the setup cycle
    logic [31:0] rdata;
    logic slverr;
    // Reply carriers toward the message and status builders
    bcs_cap_t cap;
    bcs_stat_t stat;
  } bcs_state_t;

  bcs_state_t state_q; // Registered state
  bcs_state_t state_d; // Next state

  // Register slot kinds
  typedef enum logic [4:0] {
    K_CTRL = 5'b00001,
    K_SRC = 5'b00010,
    K_STAT = 5'b00100,
    K_ID = 5'b01000,
    K_CAP = 5'b10000
  } bcs_kind_t;

  // Address decode, shared by read and write
  // Bit 5 marks a mapped address, bits 4:0 the one-hot slot kind
  // Only whole aligned words decode; odd byte addresses answer error
  function automatic logic [5:0] dec_addr(input logic [11:0] a);
    logic [5:0] r;
    // Unmapped unless a branch below matches
    r = 6'h00;
    if (a == BCS_CTRL_OFS) begin
      r = {1'b1, K_CTRL};
    end else if (a == BCS_SRC_OFS) begin
      r = {1'b1, K_SRC};
    end else if (a == BCS_STAT_OFS) begin
      r = {1'b1, K_STAT};
    end else if (a[11:5] == BCS_ID_OFS[11:5] && a[1:0] == 2'b00) begin
      r = {1'b1, K_ID};
    end else if (a[11:5] == BCS_CAP_OFS[11:5] && a[1:0] == 2'b00) begin
      r = {1'b1, K_CAP};
    end
    return r;
  endfunction

  // Battery index within the per-battery word arrays
  function automatic logic [2:0] slot(input logic [11:0] a);
    return a[4:2];
  endfunction

  // Battery powering bitmap, gated by the battery input flag
  function automatic logic [7:0] gate_map(input logic [15:0] s);
    logic [7:0] m;
    m = 8'h00;
    if (s[BCS_PSI_BATTERY]) begin
      m = s[15:8];
    end
    return m;
  endfunction

  // Builds the nine-byte capability block for one reference
  function automatic logic [71:0] build_cap(
    input logic [7:0] ref_idx,
    input logic [31:0] ctrl,
    input logic [BCS_NBAT-1:0][31:0] idw,
    input logic [BCS_NBAT-1:0][31:0] capw
  );
    // Block under construction, byte 0 in the low bits
    logic [71:0] b;
    // Slot of the battery in the word arrays
    logic [2:0] i;
    // Battery flags derived from the reference and the masks
    logic exists;
    logic hot;
    logic present;
    // Capacity fields after the absent and unknown codes
    logic [15:0] dcap;
    logic [15:0] lfcc;
    b = 72'h0;
    i = ref_idx[2:0];
    // upper half of range is hot swappable
    hot = ref_idx[BCS_HS_BIT];
    exists = (ref_idx <= BCS_LAST_REF) && ctrl[i];
    present = ctrl[8 + i];
    // Design capacity: absence wins over unknown
    if (hot && !present) begin
      dcap = BCS_CAP_ABSENT;
    end else if (ctrl[16 + i]) begin
      dcap = BCS_CAP_UNKNOWN;
    end else begin
      dcap = capw[i][15:0];
    end
    // Last full charge capacity, same precedence
    if (hot && !present) begin
      lfcc = BCS_CAP_ABSENT;
    end else if (ctrl[24 + i]) begin
      lfcc = BCS_CAP_UNKNOWN;
    end else begin
      lfcc = capw[i][31:16];
    end
    if (exists) begin
      // fields of the referenced battery only
      // vendor then product, low byte first
      b[31:0] = idw[i];
      // design capacity in bytes 4 and 5
      b[47:32] = dcap;
      // full charge capacity in bytes 6 and 7
      b[63:48] = lfcc;
      b[64 + BCS_TYPE_HOTSWAP] = hot;
    end else begin
      b[64 + BCS_TYPE_INVALID] = 1'b1;
    end
    // bits 2 to 7 of byte 8 reserved
    b[71:66] = 6'h00;
    return b;
  endfunction

  // Zero wait states; the read word is loaded in setup
  // No access ever stalls, so the master never waits
  assign pready = 1'b1;
  // Read word and error stand until the next setup
  assign prdata = state_q.rdata;
  assign pslverr = state_q.slverr;
  // Replies and status request come straight from flops
  assign cap_rsp = state_q.cap;
  assign stat_req = state_q.stat;
  // Map forced to zero while not running on battery
  assign bat_supply = gate_map(state_q.src);
  assign bat_supply_valid = state_q.src[BCS_PSI_BATTERY];

  // Next-state logic for bus, requests and replies
  always_comb begin
    logic [5:0] dk;
    logic wr;
    logic rd_setup;
    logic [31:0] rv;
    dk = dec_addr(paddr);
    wr = psel && penable && pwrite && dk[5];
    rd_setup = psel && !penable;
    rv = 32'h0;
    state_d = state_q;

    // Reply strobes are one-cycle pulses
    state_d.cap.valid = 1'b0;
    state_d.stat.valid = 1'b0;

    // Setup phase: read word and error answer
    if (rd_setup) begin
      case (dk[4:0])
        // Battery masks
        K_CTRL: begin
          rv = state_q.ctrl;
        end
        // Source fields, upper half reads zero
        K_SRC: begin
          rv = {16'h0, state_q.src};
        end
        // Count, last reference, flags and gated bitmap
        K_STAT: begin
          rv = {state_q.cap_cnt, state_q.last_ref, 6'h00,
                state_q.size_err, state_q.src[BCS_PSI_BATTERY],
                gate_map(state_q.src)};
        end
        // Identifier word of the addressed battery
        K_ID: begin
          rv = state_q.idw[slot(paddr)];
        end
        // Capacity word of the addressed battery
        K_CAP: begin
          rv = state_q.capw[slot(paddr)];
        end
        // Unmapped: zero, with the error answer below
        default: begin
          rv = 32'h0;
        end
      endcase
      // Unmapped addresses answer with an error
      state_d.rdata = pwrite ? 32'h0 : rv;
      state_d.slverr = !dk[5];
    end

    // Access phase: writes take effect at the handshake edge
    if (wr) begin
      case (dk[4:0])
        // New battery masks take effect on the next query
        K_CTRL: begin
          state_d.ctrl = pwdata;
        end
        // Source fields from the low half of the word
        K_SRC: begin
          state_d.src = pwdata[15:0];
        end
        // Only the clear bit is writable here
        K_STAT: begin
          // Write one clears the size error
          if (pwdata[BCS_STAT_SZERR]) begin
            state_d.size_err = 1'b0;
          end
        end
        // Identifier word of one battery
        K_ID: begin
          state_d.idw[slot(paddr)] = pwdata;
        end
        // Capacity word of one battery
        K_CAP: begin
          state_d.capw[slot(paddr)] = pwdata;
        end
        // Unmapped writes are dropped
        default: begin
          state_d.ctrl = state_q.ctrl;
        end
      endcase
    end

    // Incoming query from the protocol engine
    // Requests are never refused; one may come every cycle
    if (req.valid) begin
      // Kept for software, even for a bad reference
      state_d.last_ref = req.ref_idx;
      // other sizes are flagged, set beats clear
      if (req.size != BCS_REQ_SIZE) begin
        state_d.size_err = 1'b1;
      end
      if (req.is_status) begin
        // forward the reference to the status builder
        state_d.stat.valid = 1'b1;
        state_d.stat.ref_idx = req.ref_idx;
      end else begin
        state_d.cap.valid = 1'b1;
        state_d.cap.size = BCS_CAP_SIZE;
        // Uses the masks as they stood before this edge's write
        state_d.cap.block = build_cap(req.ref_idx, state_q.ctrl,
                                      state_q.idw, state_q.capw);
        // Reply counter wraps; software reads differences
        state_d.cap_cnt = state_q.cap_cnt + 8'h01;
      end
    end
  end

  // State register; asynchronous reset to constants
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Clear everything, then apply the named reset values
      // so that a changed constant needs no edit here
      state_q <= '0;
      state_q.ctrl <= BCS_CTRL_RST;
      state_q.src <= BCS_SRC_RST;
      // Every battery slot back to its reset word
      for (int k = 0; k < BCS_NBAT; k++) begin
        state_q.idw[k] <= BCS_WORD_RST;
        state_q.capw[k] <= BCS_WORD_RST;
      end
    end else begin
      // Whole state advances together
      state_q <= state_d;
    end
  end

endmodule // bcs_responder

//--- tb/bcs_partner.sv
// Port partner model that launches battery queries
`timescale 1ns/100ps
module bcs_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic is_status,
  input wire logic [7:0] ref_idx,
  output bcs_pkg::bcs_req_t req
);
  import bcs_pkg::*;
  // Query leaves one edge after the bench asks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= '0;
    end else begin
      req.valid <= go;
      req.is_status <= is_status;
      req.size <= BCS_REQ_SIZE;
      req.ref_idx <= ref_idx;
    end
  end
endmodule // bcs_partner

//--- tb/bcs_responder_assertions.sv
// Port checks for the battery query responder
`timescale 1ns/100ps
module bcs_responder_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire bcs_pkg::bcs_req_t req,
  input wire bcs_pkg::bcs_cap_t cap_rsp,
  input wire bcs_pkg::bcs_stat_t stat_req,
  input wire logic [7:0] bat_supply,
  input wire logic bat_supply_valid
);
  import bcs_pkg::*;
  default clocking ck @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Capability query, and one that names no battery
  sequence s_cq; req.valid && !req.is_status; endsequence
  sequence s_bad; s_cq ##0 req.ref_idx > BCS_LAST_REF; endsequence
  property p_cap; s_cq |=> cap_rsp.valid; endproperty
  a_cap: assert property (p_cap) else $error("no reply");
  property p_only; cap_rsp.valid |-> $past(req.valid); endproperty
  a_only: assert property (p_only) else $error("stray reply");
  property p_sz; cap_rsp.valid |-> cap_rsp.size == BCS_CAP_SIZE; endproperty
  a_sz: assert property (p_sz) else $error("bad size");
  property p_rsv; cap_rsp.valid |-> cap_rsp.block[71:66] == 6'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_bad; s_bad |=> cap_rsp.block == {8'h01, 64'h0}; endproperty
  a_bad: assert property (p_bad) else $error("bad ref");
  property p_hot; s_cq ##0 req.ref_idx <= BCS_LAST_REF
    |=> cap_rsp.block[65] == ($past(req.ref_idx[2]) && !cap_rsp.block[64]);
  endproperty
  a_hot: assert property (p_hot) else $error("hot bit");
  property p_st; req.valid && req.is_status
    |=> stat_req.valid && stat_req.ref_idx == $past(req.ref_idx);
  endproperty
  a_st: assert property (p_st) else $error("status");
  property p_bmp; !bat_supply_valid |-> bat_supply == 8'h00; endproperty
  a_bmp: assert property (p_bmp) else $error("bitmap");
endmodule // bcs_responder_assertions
bind bcs_responder bcs_responder_assertions chk_u (.pclk(pclk),
  .presetn(presetn), .req(req), .cap_rsp(cap_rsp), .stat_req(stat_req),
  .bat_supply(bat_supply), .bat_supply_valid(bat_supply_valid));

//--- tb/bcs_responder_test.sv
// Self-checking bench for the battery query responder
`timescale 1ns/100ps
module bcs_responder_test;
  import bcs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, go = 0, ask_st = 0, bat_supply_valid;
  logic [7:0] ask_ref = 8'h00, bat_supply;
  bcs_req_t req;
  bcs_cap_t cap_rsp, cap_seen;
  bcs_stat_t stat_req, stat_seen;
  int n_fail = 0, comparisons = 0;
  // Battery 7 missing, only 4 present, some capacities unknown
  localparam logic [31:0] CTRL = 32'h2432_107f;
  always #4 pclk = ~pclk;
  bcs_partner prt_u (.pclk(pclk), .presetn(presetn), .go(go),
    .is_status(ask_st), .ref_idx(ask_ref), .req(req));
  bcs_responder dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
    .cap_rsp(cap_rsp), .stat_req(stat_req), .bat_supply(bat_supply),
    .bat_supply_valid(bat_supply_valid));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [71:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following setup never rewrites this release
    @(posedge pclk);
    if (i == 8) begin
      n_fail++;
      tally_and_finish;
    end
  endtask
  // Ask the partner for a query and wait for the answer
  task automatic ask(input logic st, input logic [7:0] r);
    int i;
    go <= 1'b1;
    ask_st <= st;
    ask_ref <= r;
    @(posedge pclk);
    go <= 1'b0;
    for (i = 0; i < 6; i++) begin
      // Mid-cycle look, away from the edge that launches the reply
      @(negedge pclk);
      if (cap_rsp.valid === 1'b1 || stat_req.valid === 1'b1) break;
    end
    cap_seen = cap_rsp;
    stat_seen = stat_req;
    // Back onto the rising edge before the next stimulus
    @(posedge pclk);
    if (i == 6) begin
      n_fail++;
      tally_and_finish;
    end
  endtask
  function automatic logic [71:0] exp_blk(input logic [7:0] r);
    logic [15:0] d, f;
    logic hot;
    if (r > 8'h07 || !CTRL[r[2:0]]) return {8'h01, 64'h0};
    hot = r[2];
    d = CTRL[16 + r[2:0]] ? 16'hffff : 16'h0300 + 16'(r);
    f = CTRL[24 + r[2:0]] ? 16'hffff : 16'h0200 + 16'(r);
    // Absence wins over unknown
    if (hot && !CTRL[8 + r[2:0]]) begin
      d = 16'h0;
      f = 16'h0;
    end
    return {6'h0, hot, 1'b0, f, d, 16'h2000 + 16'(r), 16'h1000 + 16'(r)};
  endfunction
  task automatic t_src;
    apb(1'b0, BCS_CTRL_OFS, 32'h0);
    chk(72'(rd), 72'(BCS_CTRL_RST));
    apb(1'b1, 12'h100, 32'h1);
    chk(72'(err), 72'h1);
    apb(1'b1, BCS_SRC_OFS, 32'h3108);
    chk(72'({bat_supply_valid, bat_supply}), 72'h131);
    apb(1'b1, BCS_SRC_OFS, 32'h3100);
    chk(72'({bat_supply_valid, bat_supply}), 72'h0);
    $display("t_src done");
  endtask
  task automatic t_cap;
    int i;
    logic [7:0] r;
    for (i = 0; i < 8; i++) begin
      apb(1'b1, BCS_ID_OFS + 12'(4 * i),
        {16'h2000 + 16'(i), 16'h1000 + 16'(i)});
      apb(1'b1, BCS_CAP_OFS + 12'(4 * i),
        {16'h0200 + 16'(i), 16'h0300 + 16'(i)});
    end
    // Words read back from their slots
    apb(1'b0, BCS_ID_OFS + 12'h00c, 32'h0);
    chk(72'(rd), 72'h2003_1003);
    apb(1'b0, BCS_CAP_OFS + 12'h014, 32'h0);
    chk(72'(rd), 72'h0205_0305);
    apb(1'b1, BCS_CTRL_OFS, CTRL);
    for (i = 0; i < 10; i++) begin
      r = (i == 9) ? 8'hff : 8'(i);
      ask(1'b0, r);
      chk(cap_seen.block, exp_blk(r));
    end
    $display("t_cap done");
  endtask
  task automatic t_stat;
    ask(1'b1, 8'h06);
    chk(72'({stat_seen.valid, stat_seen.ref_idx}), 72'h106);
    chk(72'(cap_seen.valid), 72'h0);
    // Ten replies counted, last reference six, no size error
    apb(1'b0, BCS_STAT_OFS, 32'h0);
    chk(72'(rd), 72'h0a06_0000);
    $display("t_stat done");
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_src;
    t_cap;
    t_stat;
    tally_and_finish;
  end
endmodule // bcs_responder_test
